// >>> ee_dev.sv
// eeprom target end: bus condition detection, control decode, page buffer, write cycle
// assumes scl and sda come from another domain and are synchronised here
`timescale 1ns/1ps
module ee_dev #(
	parameter int WC_CYCLES = ee_pkg::WC_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	ee_if.dev bus,
	input wire logic [2:0] chip_select_pins,
	input wire logic wp_pin,
	input wire logic [ee_pkg::ADDR_W-1:0] peek_addr,
	output logic [ee_pkg::BYTE_W-1:0] peek_data,
	output logic busy
);
	localparam int TW = $clog2(WC_CYCLES + 1);

	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic [1:0] wp_sync_r;
	logic [2:0] cs_sync0_r;
	logic [2:0] cs_sync1_r;
	logic scl_d_r;
	logic sda_d_r;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	ee_pkg::ee_phase_t phase_r;
	logic [3:0] bitcnt_r;
	logic [ee_pkg::BYTE_W-1:0] shift_r;
	logic ack_phase_r;
	logic ack_r;
	logic byte_done;
	logic ctrl_match;
	logic [ee_pkg::ADDR_W-1:0] ptr_r;
	logic [ee_pkg::BYTE_W-1:0] page_buf [ee_pkg::PAGE_SIZE];
	logic [ee_pkg::PAGE_SIZE-1:0] mask_r;
	logic [ee_pkg::BYTE_W-1:0] mem [ee_pkg::MEM_DEPTH];
	logic [TW-1:0] timer_r;
	logic busy_r;
	logic launch;

	// pins cross into mclk through two flops; the extra stage feeds edge detection
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], bus.scl};
			sda_sync_r <= {sda_sync_r[0], bus.sda};
			scl_d_r <= scl_sync_r[1];
			sda_d_r <= sda_sync_r[1];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wp_sync_r <= 2'h3;
			cs_sync0_r <= 3'h0;
			cs_sync1_r <= 3'h0;
		end else begin
			wp_sync_r <= {wp_sync_r[0], wp_pin};
			cs_sync0_r <= chip_select_pins;
			cs_sync1_r <= cs_sync0_r;
		end
	end

	assign scl_s = scl_sync_r[1];
	assign sda_s = sda_sync_r[1];
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
	assign byte_done = scl_fall && !ack_phase_r && (bitcnt_r == ee_pkg::ACK_BIT);

	// control byte: code high nibble, selects, direction last
	assign ctrl_match = (shift_r[7:ee_pkg::CTRL_CODE_LO] == ee_pkg::DEV_CODE)
		&& (shift_r[3:ee_pkg::CTRL_CS_LO] == cs_sync1_r);

	// bit engine and command phase
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= ee_pkg::EE_PH_IDLE;
			bitcnt_r <= 4'h0;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
			ack_r <= 1'b0;
		end else if (start_det) begin
			phase_r <= ee_pkg::EE_PH_CTRL;
			bitcnt_r <= 4'h0;
			ack_phase_r <= 1'b0;
			ack_r <= 1'b0;
		end else if (stop_det) begin
			phase_r <= ee_pkg::EE_PH_IDLE;
			bitcnt_r <= 4'h0;
			ack_phase_r <= 1'b0;
			ack_r <= 1'b0;
		end else if (scl_fall && ack_phase_r) begin
			ack_phase_r <= 1'b0;
			ack_r <= 1'b0;
			bitcnt_r <= 4'h0;
		end else if (scl_rise && phase_r != ee_pkg::EE_PH_IDLE
			&& bitcnt_r != ee_pkg::ACK_BIT) begin
			shift_r <= {shift_r[6:0], sda_s};
			bitcnt_r <= bitcnt_r + 4'h1;
		end else if (byte_done && phase_r != ee_pkg::EE_PH_IDLE) begin
			ack_phase_r <= 1'b1;
			case (phase_r)
				ee_pkg::EE_PH_CTRL: begin
					ack_r <= ctrl_match && !busy_r;
					if (!ctrl_match || busy_r) begin
						phase_r <= ee_pkg::EE_PH_IDLE;
					end else if (shift_r[ee_pkg::CTRL_RW] == ee_pkg::RW_READ) begin
						phase_r <= ee_pkg::EE_PH_SKIP;
					end else begin
						phase_r <= ee_pkg::EE_PH_ADDR;
					end
				end
				ee_pkg::EE_PH_ADDR: begin
					ack_r <= !busy_r;
					phase_r <= ee_pkg::EE_PH_DATA;
				end
				ee_pkg::EE_PH_DATA: begin
					ack_r <= !busy_r;
				end
				default: begin
					// read transmit lies elsewhere; sda stays released
					ack_r <= 1'b0;
				end
			endcase
		end
	end

	// open-drain: enable pulls low for the whole ack high phase
	assign bus.dev_sda_oe = ack_r;
	assign bus.dev_sda_o = 1'b0;

	// address pointer: msb of word address dropped, low nibble wraps in page
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_r <= 7'h00;
		end else if (byte_done && phase_r == ee_pkg::EE_PH_ADDR) begin
			ptr_r <= shift_r[ee_pkg::ADDR_W-1:0];
		end else if (byte_done && phase_r == ee_pkg::EE_PH_DATA) begin
			ptr_r <= {ptr_r[ee_pkg::ADDR_W-1:ee_pkg::PAGE_W],
				ptr_r[ee_pkg::PAGE_W-1:0] + 4'h1};
		end
	end

	// page buffer: a wrapped pointer overwrites the oldest byte first
	always_ff @(posedge mclk) begin
		if (byte_done && phase_r == ee_pkg::EE_PH_DATA) begin
			page_buf[ptr_r[ee_pkg::PAGE_W-1:0]] <= shift_r;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= 16'h0000;
		end else if (byte_done && phase_r == ee_pkg::EE_PH_CTRL) begin
			mask_r <= 16'h0000;
		end else if (byte_done && phase_r == ee_pkg::EE_PH_DATA) begin
			mask_r[ptr_r[ee_pkg::PAGE_W-1:0]] <= 1'b1;
		end else if (launch) begin
			mask_r <= 16'h0000;
		end
	end

	// a stop after at least one data byte starts the timed write
	assign launch = stop_det && phase_r == ee_pkg::EE_PH_DATA
		&& mask_r != 16'h0000 && !busy_r;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			timer_r <= '0;
		end else if (launch) begin
			busy_r <= 1'b1;
			timer_r <= TW'(WC_CYCLES - 1);
		end else if (busy_r) begin
			if (timer_r == '0) begin
				busy_r <= 1'b0;
			end else begin
				timer_r <= timer_r - TW'(1);
			end
		end
	end

	// array commit at launch; protect pin gates the store only
	always_ff @(posedge mclk) begin
		if (launch && !wp_sync_r[1]) begin
			for (int i = 0; i < ee_pkg::PAGE_SIZE; i++) begin
				if (mask_r[i]) begin
					mem[{ptr_r[ee_pkg::ADDR_W-1:ee_pkg::PAGE_W], 4'(i)}] <= page_buf[i];
				end
			end
		end
	end

	// read path to the array is untouched by the protect pin
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			peek_data <= 8'h00;
		end else begin
			peek_data <= mem[peek_addr];
		end
	end

	assign busy = busy_r;
endmodule

// >>> ee_host.sv
// bus master end: makes scl from mclk, sends byte and page writes from a data fifo
// assumes one target on ee_if; sda arrives from the line and is synchronised here
`timescale 1ns/1ps
module ee_fifo #(
	parameter int W = ee_pkg::BYTE_W,
	parameter int DEPTH = ee_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] store [DEPTH];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;

	assign out_valid = wr_r != rd_r;
	assign in_ready = wr_r != {~rd_r[AW], rd_r[AW-1:0]};
	assign out_data = store[rd_r[AW-1:0]];

	always_ff @(posedge mclk) begin
		if (in_valid && in_ready) begin
			store[wr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_r <= wr_r + (AW+1)'(1);
			end
			if (out_valid && out_ready) begin
				rd_r <= rd_r + (AW+1)'(1);
			end
		end
	end
endmodule

module ee_host #(
	parameter int QTR_CYCLES = ee_pkg::QTR_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	ee_if.host bus,
	input wire logic go,
	input wire logic [2:0] go_cs,
	input wire logic [ee_pkg::ADDR_W-1:0] go_addr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [ee_pkg::BYTE_W-1:0] in_data,
	output logic busy,
	output logic done,
	output logic nack
);
	localparam int DW = $clog2(QTR_CYCLES + 1);
	logic [DW-1:0] div_r;
	logic tick;
	logic [1:0] sda_sync_r;
	logic sda_s;
	ee_pkg::ee_hstate_t st_r;
	logic [1:0] q_r;
	logic [3:0] bit_r;
	logic [ee_pkg::BYTE_W-1:0] shift_r;
	logic [ee_pkg::ADDR_W-1:0] addr_r;
	logic addr_sent_r;
	logic scl_r;
	logic pull_r;
	logic fifo_valid;
	logic fifo_pop;
	logic [ee_pkg::BYTE_W-1:0] fifo_data;

	ee_fifo #(.W(ee_pkg::BYTE_W), .DEPTH(ee_pkg::FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// quarter bit enable from the divider
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_r <= '0;
		end else if (div_r == DW'(QTR_CYCLES - 1)) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + DW'(1);
		end
	end
	assign tick = div_r == DW'(QTR_CYCLES - 1);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sda_sync_r <= 2'h3;
		end else begin
			sda_sync_r <= {sda_sync_r[0], bus.sda};
		end
	end
	assign sda_s = sda_sync_r[1];

	// data byte pops only at the end of an acked byte past the control byte
	assign fifo_pop = tick && st_r == ee_pkg::EE_H_BIT && q_r == 2'h3
		&& bit_r == ee_pkg::ACK_BIT && !sda_s && addr_sent_r && fifo_valid;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ee_pkg::EE_H_IDLE;
			q_r <= 2'h0;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			addr_r <= 7'h00;
			addr_sent_r <= 1'b0;
			scl_r <= 1'b1;
			pull_r <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st_r)
				ee_pkg::EE_H_IDLE: begin
					if (go && sda_s && scl_r) begin
						shift_r <= {ee_pkg::DEV_CODE, go_cs, ee_pkg::RW_WRITE};
						addr_r <= go_addr;
						addr_sent_r <= 1'b0;
						nack <= 1'b0;
						q_r <= 2'h0;
						st_r <= ee_pkg::EE_H_START;
					end
				end
				ee_pkg::EE_H_START: begin
					if (tick) begin
						q_r <= q_r + 2'h1;
						if (q_r == 2'h0) begin
							pull_r <= 1'b1;
						end else if (q_r == 2'h1) begin
							scl_r <= 1'b0;
							bit_r <= 4'h0;
							q_r <= 2'h0;
							st_r <= ee_pkg::EE_H_BIT;
						end
					end
				end
				ee_pkg::EE_H_BIT: begin
					if (tick) begin
						q_r <= q_r + 2'h1;
						if (q_r == 2'h0) begin
							// release for the ninth clock so the target can ack
							pull_r <= bit_r != ee_pkg::ACK_BIT && !shift_r[7];
						end else if (q_r == 2'h1) begin
							scl_r <= 1'b1;
						end else if (q_r == 2'h3) begin
							scl_r <= 1'b0;
							if (bit_r != ee_pkg::ACK_BIT) begin
								shift_r <= {shift_r[6:0], 1'b0};
								bit_r <= bit_r + 4'h1;
							end else begin
								bit_r <= 4'h0;
								if (sda_s) begin
									nack <= 1'b1;
									st_r <= ee_pkg::EE_H_STOP;
								end else if (!addr_sent_r) begin
									shift_r <= {1'b0, addr_r};
									addr_sent_r <= 1'b1;
								end else if (fifo_valid) begin
									shift_r <= fifo_data;
								end else begin
									st_r <= ee_pkg::EE_H_STOP;
								end
							end
						end
					end
				end
				ee_pkg::EE_H_STOP: begin
					if (tick) begin
						q_r <= q_r + 2'h1;
						if (q_r == 2'h0) begin
							pull_r <= 1'b1;
						end else if (q_r == 2'h1) begin
							scl_r <= 1'b1;
						end else if (q_r == 2'h2) begin
							pull_r <= 1'b0;
							done <= 1'b1;
							q_r <= 2'h0;
							st_r <= ee_pkg::EE_H_IDLE;
						end
					end
				end
				default: begin
					st_r <= ee_pkg::EE_H_IDLE;
				end
			endcase
		end
	end

	assign bus.scl = scl_r;
	assign bus.host_sda_oe = pull_r;
	assign bus.host_sda_o = 1'b0;
	assign busy = st_r != ee_pkg::EE_H_IDLE;
endmodule

// >>> ee_if.sv
// two-wire bus carrier between the eeprom target and its master
// assumes open-drain sda: each end pulls low while its enable is high
`timescale 1ns/1ps
interface ee_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// >>> ee_pkg.sv
// shared constants and types for the two-wire eeprom target and its bus master
// assumes both ends run on one 100 MHz clock and meet through ee_if
// How it works
// - write protect high blocks array changes only
// - master alone clocks, starts and stops
// - sda falling while scl high starts
// - sda rising while scl high stops
// - one bit per clock, sampled high
// - master starts only on idle bus
// - only last sixteen data bytes kept
// - receiver acks every byte, ninth clock
// - no acknowledge during programming cycle
// - ack holds sda low through high
// - released sda lets master stop
// - control byte: code, selects, direction
// - ack control only on full match
// - direction one reads, zero writes
// - byte write: control, address, data, stop
// - stop after write launches timed cycle
// - protected write acked, nothing stored
// - page write buffers, commits after stop
// - only low pointer nibble increments, wraps
// - host avoids page crossing writes; ee_host sends every queued byte, so the target wraps in page
// - no sequential run across devices
// - short package sends select two zero
// - write cycle ends within five ms
package ee_pkg;
	localparam int CLK_MHZ = 100;
	localparam int T_WC_MS = 5;
	localparam int WC_CYCLES = T_WC_MS * 1000 * CLK_MHZ;
	localparam int F_SCL_KHZ = 400;
	localparam int QTR_CYCLES = (CLK_MHZ * 1000) / (F_SCL_KHZ * 4);
	localparam logic [3:0] DEV_CODE = 4'hA;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 7;
	localparam int PAGE_W = 4;
	localparam int PAGE_SIZE = 16;
	localparam int MEM_DEPTH = 128;
	localparam int FIFO_DEPTH = 32;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam int CTRL_CODE_LO = 4;
	localparam int CTRL_CS_LO = 1;
	localparam int CTRL_RW = 0;
	localparam logic RW_READ = 1'b1;
	localparam logic RW_WRITE = 1'b0;
	typedef enum logic [2:0] {EE_PH_IDLE, EE_PH_CTRL, EE_PH_ADDR, EE_PH_DATA, EE_PH_SKIP} ee_phase_t;
	typedef enum logic [1:0] {EE_H_IDLE, EE_H_START, EE_H_BIT, EE_H_STOP} ee_hstate_t;
endpackage

// >>> ee_properties.sv
// concurrent checks on the two-wire link between the eeprom target and its master
// assumes one mclk domain and takes the ee_if signals as plain inputs
`timescale 1ns/1ps
module ee_properties #(
	parameter int QTR_CYCLES = ee_pkg::QTR_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	localparam int LO_MIN = 2 * QTR_CYCLES - 1;
	localparam int LO_MAX = 2 * QTR_CYCLES + 1;
	localparam int ACK_MIN = 2 * QTR_CYCLES - 5;
	localparam int ACK_MAX = 2 * QTR_CYCLES - 2;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_scl_low_time: assert property ($fell(scl) |-> ##[LO_MIN:LO_MAX] $rose(scl))
		else $error("scl low phase has the wrong length");
	a_start_hold: assert property ($rose(host_sda_oe) && scl |-> (scl && !sda)[*4])
		else $error("start condition not held with scl high");
	a_stop_idle: assert property ($rose(sda) && scl |=> (scl && sda)[*3])
		else $error("bus not idle after stop");
	a_bit_stable: assert property ($rose(scl) |=> $stable(sda)[*4])
		else $error("sda moved while scl high");
	a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target changed sda while scl high");
	a_ack_low_high: assert property ($rose(scl) && dev_sda_oe |-> (dev_sda_oe && !sda)[*8])
		else $error("ack not held low through scl high");
	a_ack_release: assert property ($fell(scl) && dev_sda_oe |-> ##[2:6] !dev_sda_oe)
		else $error("target did not release sda after ack");
	a_ack_timing: assert property ($rose(dev_sda_oe) |-> ##[ACK_MIN:ACK_MAX] $rose(scl))
		else $error("ack pull not placed before the ninth clock");
endmodule

// >>> test_serial_eeprom_i2c_write_slave.sv
// self-checking bench: eeprom target and master joined by ee_if, fed from the fifo side
// assumes ee_pkg, ee_if, ee_dev, ee_host and ee_properties are compiled first
`timescale 1ns/1ps
module test_serial_eeprom_i2c_write_slave;
	localparam int WC = 2000;
	localparam int QTR = 8;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic go = 1'b0;
	logic [2:0] go_cs = 3'h0;
	logic [6:0] go_addr = 7'h00;
	logic in_valid = 1'b0;
	logic in_ready;
	logic [7:0] in_data = 8'h00;
	logic busy;
	logic done;
	logic nack;
	logic dev_busy;
	logic [2:0] cs_pins = 3'h5;
	logic wp_pin = 1'b0;
	logic [6:0] peek_addr = 7'h00;
	logic [7:0] peek_data;
	int num_errors = 0;
	int samples_checked = 0;
	ee_if ee_if_i ();
	ee_dev #(.WC_CYCLES(WC)) ee_dev_i (.mclk(mclk), .reset_n(reset_n), .bus(ee_if_i),
		.chip_select_pins(cs_pins), .wp_pin(wp_pin), .peek_addr(peek_addr),
		.peek_data(peek_data), .busy(dev_busy));
	ee_host #(.QTR_CYCLES(QTR)) ee_host_i (.mclk(mclk), .reset_n(reset_n), .bus(ee_if_i),
		.go(go), .go_cs(go_cs), .go_addr(go_addr), .in_valid(in_valid), .in_ready(in_ready),
		.in_data(in_data), .busy(busy), .done(done), .nack(nack));
	ee_properties #(.QTR_CYCLES(QTR)) ee_properties_i (.mclk(mclk), .reset_n(reset_n),
		.scl(ee_if_i.scl), .host_sda_o(ee_if_i.host_sda_o), .host_sda_oe(ee_if_i.host_sda_oe),
		.dev_sda_o(ee_if_i.dev_sda_o), .dev_sda_oe(ee_if_i.dev_sda_oe), .sda(ee_if_i.sda));
	always #5 mclk = ~mclk;
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
			num_errors++;
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// pushes words while the fifo accepts them
	task automatic fill(input logic [7:0] base, input int max, output int n);
		n = 0;
		while (in_ready === 1'b1 && n < max) begin
			in_valid = 1'b1;
			in_data = base + n[7:0];
			@(negedge mclk);
			n++;
		end
		in_valid = 1'b0;
	endtask
	task automatic run(input logic [2:0] cs, input logic [6:0] addr, input logic exp_nack);
		int n;
		n = 0;
		go_cs = cs;
		go_addr = addr;
		go = 1'b1;
		while (busy !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		check("host busy", 1, {31'h0, busy});
		go = 1'b0;
		while (done !== 1'b1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		check("done pulse", 1, {31'h0, done});
		check("nack", {31'h0, exp_nack}, {31'h0, nack});
	endtask
	task automatic wait_busy(input logic lvl, input int lim, output int n);
		n = 0;
		while (dev_busy !== lvl && n < lim) begin
			@(negedge mclk);
			n++;
		end
	endtask
	task automatic peek(input logic [6:0] a, input logic [7:0] exp);
		peek_addr = a;
		@(negedge mclk);
		check("array byte", {24'h0, exp}, {24'h0, peek_data});
	endtask
	task automatic t_byte_write();
		int n;
		fill(8'h3C, 1, n);
		run(3'h5, 7'h13, 1'b0);
		wait_busy(1'b1, 20, n);
		wait_busy(1'b0, 3 * WC, n);
		check("write cycle length", WC, n);
		peek(7'h13, 8'h3C);
	endtask
	task automatic t_page_wrap();
		int n;
		fill(8'h40, 40, n);
		check("fifo words", 32, n);
		run(3'h5, 7'h2E, 1'b0);
		wait_busy(1'b1, 20, n);
		wait_busy(1'b0, 3 * WC, n);
		check("page write cycle length", WC, n);
		check("fifo drained", 1, {31'h0, in_ready});
		for (int i = 16; i < 32; i++) begin
			peek(7'h20 + 7'((14 + i) % 16), 8'(8'h40 + i));
		end
	endtask
	task automatic t_wp_poll();
		int n;
		wp_pin = 1'b1;
		fill(8'hA5, 1, n);
		run(3'h5, 7'h13, 1'b0);
		wait_busy(1'b1, 20, n);
		check("busy after protected write", 1, {31'h0, dev_busy});
		run(3'h5, 7'h13, 1'b1);
		wait_busy(1'b0, 3 * WC, n);
		check("busy after write cycle", 0, {31'h0, dev_busy});
		run(3'h5, 7'h13, 1'b0);
		peek(7'h13, 8'h3C);
		wp_pin = 1'b0;
	endtask
	task automatic t_cs_miss();
		run(3'h2, 7'h00, 1'b1);
		check("busy after refused control", 0, {31'h0, dev_busy});
		cs_pins = 3'h2;
		run(3'h2, 7'h00, 1'b0);
		cs_pins = 3'h5;
	endtask
	initial begin
		repeat (4) @(negedge mclk);
		reset_n = 1'b1;
		repeat (3) @(negedge mclk);
		t_byte_write();
		t_page_wrap();
		t_wp_poll();
		t_cs_miss();
		close_out();
	end
	// cuts a hang short well past the expected run length
	initial begin
		#1000000;
		num_errors++;
		close_out();
	end
endmodule
